// File: design/eeprom_cmd_engine.sv
/*
  APB-mapped command engine driving a three-wire serial EEPROM.
  Assumes an APB master on clk, a pulled data-in pin from the EEPROM, and
  that software honours the busy bit before issuing further commands.
*/
module eeprom_cmd_engine #(
  parameter int unsigned TIMEOUT_CYCLES = eeprom_cmd_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire eeprom_cmd_pkg::apb_req_s apbReq,
  output eeprom_cmd_pkg::apb_rsp_s apbRsp,
  output eeprom_cmd_pkg::ee_pins_s eePins,
  input wire logic serialDataInPin,
  input wire logic [2:0] cfgRdAddr,
  output logic [7:0] cfgRdData
);

  localparam logic [eeprom_cmd_pkg::TMO_W-1:0] TMO_LAST =
    eeprom_cmd_pkg::TMO_W'(TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic needs_wait(input logic [2:0] op);
    needs_wait = (op == eeprom_cmd_pkg::OP_WRITE) || (op == eeprom_cmd_pkg::OP_WALL) ||
                 (op == eeprom_cmd_pkg::OP_ERASE) || (op == eeprom_cmd_pkg::OP_EALL);
  endfunction

  function automatic logic [19:0] build_frame(input logic [2:0] op, input logic [8:0] a,
                                              input logic [7:0] d);
    case (op)
      eeprom_cmd_pkg::OP_READ: build_frame = {eeprom_cmd_pkg::MW_READ, a, 8'h00};
      eeprom_cmd_pkg::OP_WRITE: build_frame = {eeprom_cmd_pkg::MW_WRITE, a, d};
      eeprom_cmd_pkg::OP_ERASE: build_frame = {eeprom_cmd_pkg::MW_ERASE, a, 8'h00};
      eeprom_cmd_pkg::OP_WEN: build_frame = {eeprom_cmd_pkg::MW_SPECIAL,
                                             eeprom_cmd_pkg::MW_SUB_WEN, 7'h00, 8'h00};
      eeprom_cmd_pkg::OP_WALL: build_frame = {eeprom_cmd_pkg::MW_SPECIAL,
                                              eeprom_cmd_pkg::MW_SUB_WALL, 7'h00, d};
      eeprom_cmd_pkg::OP_EALL: build_frame = {eeprom_cmd_pkg::MW_SPECIAL,
                                              eeprom_cmd_pkg::MW_SUB_EALL, 7'h00, 8'h00};
      default: build_frame = {eeprom_cmd_pkg::MW_SPECIAL,
                              eeprom_cmd_pkg::MW_SUB_WDIS, 7'h00, 8'h00};
    endcase
  endfunction

  function automatic logic [4:0] frame_len(input logic [2:0] op);
    case (op)
      eeprom_cmd_pkg::OP_READ, eeprom_cmd_pkg::OP_WRITE,
      eeprom_cmd_pkg::OP_WALL: frame_len = eeprom_cmd_pkg::LEN_LONG;
      default: frame_len = eeprom_cmd_pkg::LEN_SHORT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  eeprom_cmd_pkg::eng_state_e stateQ, stateD;
  eeprom_cmd_pkg::apb_rsp_s rspQ, rspD;
  logic busyQ, busyD, bootQ, bootD, loadingQ, loadingD;
  logic timeoutQ, timeoutD, loadedQ, loadedD;
  logic [2:0] opQ, opD;
  logic [8:0] addrQ, addrD;
  logic [7:0] dataQ, dataD, rxQ, rxD, phaseQ, phaseD;
  logic [19:0] txQ, txD;
  logic [4:0] bitsQ, bitsD;
  logic csQ, csD, skQ, skD;
  logic [3:0] loadIdxQ, loadIdxD;
  logic [eeprom_cmd_pkg::TMO_W-1:0] tmoQ, tmoD;
  logic diMeta, diSync;
  logic wrAcc, wrCmd, start, storeWe, halfDone;
  logic [31:0] cmdView;

  // Pin comes from outside the clock domain
  always_ff @(posedge clk) begin
    diMeta <= serialDataInPin;
    diSync <= diMeta;
  end

  assign wrAcc = apbReq.psel && apbReq.penable && rspQ.pready && apbReq.pwrite;
  assign wrCmd = wrAcc && (apbReq.paddr == eeprom_cmd_pkg::ADDR_CMD);
  assign halfDone = (phaseQ == eeprom_cmd_pkg::SK_HALF_LAST);
  assign cmdView = {busyQ, opQ, 17'h00000, timeoutQ, loadedQ, addrQ};

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    stateD = stateQ;
    busyD = busyQ;
    bootD = bootQ;
    loadingD = loadingQ;
    timeoutD = timeoutQ;
    loadedD = loadedQ;
    opD = opQ;
    addrD = addrQ;
    dataD = dataQ;
    rxD = rxQ;
    phaseD = phaseQ;
    txD = txQ;
    bitsD = bitsQ;
    csD = csQ;
    skD = skQ;
    loadIdxD = loadIdxQ;
    tmoD = tmoQ;
    storeWe = 1'b0;
    start = 1'b0;
    rspD.pready = apbReq.psel && !apbReq.penable;
    rspD.pslverr = 1'b0;
    rspD.prdata = 32'h00000000;
    // Setup phase: register the answer so the access phase has no wait
    if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      if (apbReq.paddr == eeprom_cmd_pkg::ADDR_CMD) begin
        rspD.prdata = cmdView;
      end else if (apbReq.paddr == eeprom_cmd_pkg::ADDR_DATA) begin
        rspD.prdata = {24'h000000, dataQ};
      end
    end
    if (apbReq.psel && !apbReq.penable && (apbReq.paddr != eeprom_cmd_pkg::ADDR_CMD) &&
        (apbReq.paddr != eeprom_cmd_pkg::ADDR_DATA)) begin
      rspD.pslverr = 1'b1;
    end
    // Register writes; fields frozen while busy so a running command stays coherent
    if (wrCmd) begin
      if (!busyQ) begin
        opD = apbReq.pwdata[eeprom_cmd_pkg::OP_HI:eeprom_cmd_pkg::OP_LO];
        addrD = apbReq.pwdata[eeprom_cmd_pkg::ADDR_HI:0];
        start = apbReq.pwdata[eeprom_cmd_pkg::BUSY_BIT];
      end
      if (apbReq.pwdata[eeprom_cmd_pkg::TIMEOUT_BIT]) begin
        timeoutD = 1'b0;
      end
      if (apbReq.pwdata[eeprom_cmd_pkg::LOADED_BIT]) begin
        loadedD = 1'b0;
      end
    end
    if (wrAcc && (apbReq.paddr == eeprom_cmd_pkg::ADDR_DATA) && !busyQ) begin
      dataD = apbReq.pwdata[7:0];
    end
    case (stateQ)
      eeprom_cmd_pkg::ST_IDLE: begin
        if (bootQ || start) begin
          busyD = 1'b1;
          bootD = 1'b0;
          phaseD = 8'h00;
          skD = 1'b0;
          csD = 1'b1;
          stateD = eeprom_cmd_pkg::ST_FRAME;
          if (bootQ || (opD == eeprom_cmd_pkg::OP_RELOAD)) begin
            loadingD = 1'b1;
            loadIdxD = 4'h0;
            txD = build_frame(eeprom_cmd_pkg::OP_READ, 9'h000, 8'h00);
            bitsD = eeprom_cmd_pkg::LEN_LONG;
          end else begin
            txD = build_frame(opD, addrD, dataD);
            bitsD = frame_len(opD);
          end
        end
      end
      eeprom_cmd_pkg::ST_FRAME: begin
        phaseD = phaseQ + 8'h01;
        if (halfDone) begin
          phaseD = 8'h00;
          skD = !skQ;
          if (skQ) begin
            // Sample just before the falling edge: data settled since the rise
            rxD = {rxQ[6:0], diSync};
            txD = {txQ[18:0], 1'b0};
            bitsD = bitsQ - 5'h01;
            if (bitsQ == 5'h01) begin
              csD = 1'b0;
              if (!loadingQ && needs_wait(opQ)) begin
                stateD = eeprom_cmd_pkg::ST_GAP;
              end else begin
                stateD = eeprom_cmd_pkg::ST_NEXT;
              end
            end
          end
        end
      end
      eeprom_cmd_pkg::ST_GAP: begin
        phaseD = phaseQ + 8'h01;
        if (halfDone) begin
          phaseD = 8'h00;
          csD = 1'b1;
          tmoD = '0;
          stateD = eeprom_cmd_pkg::ST_WAIT;
        end
      end
      eeprom_cmd_pkg::ST_WAIT: begin
        tmoD = tmoQ + eeprom_cmd_pkg::TMO_W'(1);
        if (diSync) begin
          csD = 1'b0;
          stateD = eeprom_cmd_pkg::ST_NEXT;
        end else if (tmoQ == TMO_LAST) begin
          csD = 1'b0;
          timeoutD = 1'b1;
          stateD = eeprom_cmd_pkg::ST_NEXT;
        end
      end
      eeprom_cmd_pkg::ST_NEXT: begin
        if (!loadingQ) begin
          if (opQ == eeprom_cmd_pkg::OP_READ) begin
            dataD = rxQ;
          end
          busyD = 1'b0;
          stateD = eeprom_cmd_pkg::ST_IDLE;
        end else if ((loadIdxQ == 4'h0) && (rxQ != eeprom_cmd_pkg::VALID_MARKER)) begin
          // Marker checked before any byte is stored, so a failure touches nothing
          loadingD = 1'b0;
          busyD = 1'b0;
          stateD = eeprom_cmd_pkg::ST_IDLE;
        end else begin
          storeWe = (loadIdxQ != 4'h0);
          if (loadIdxQ == eeprom_cmd_pkg::CFG_LAST) begin
            loadingD = 1'b0;
            busyD = 1'b0;
            loadedD = 1'b1;
            stateD = eeprom_cmd_pkg::ST_IDLE;
          end else begin
            loadIdxD = loadIdxQ + 4'h1;
            txD = build_frame(eeprom_cmd_pkg::OP_READ, {5'h00, loadIdxD}, 8'h00);
            bitsD = eeprom_cmd_pkg::LEN_LONG;
            csD = 1'b1;
            phaseD = 8'h00;
            stateD = eeprom_cmd_pkg::ST_FRAME;
          end
        end
      end
      default: begin
        stateD = eeprom_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= eeprom_cmd_pkg::ST_IDLE;
      busyQ <= 1'b1;
      bootQ <= 1'b1;
      loadingQ <= 1'b0;
      timeoutQ <= 1'b0;
      loadedQ <= 1'b0;
      opQ <= eeprom_cmd_pkg::OP_RESET;
      addrQ <= eeprom_cmd_pkg::ADDR_RESET;
      dataQ <= eeprom_cmd_pkg::DATA_RESET;
      rxQ <= 8'h00;
      phaseQ <= 8'h00;
      txQ <= 20'h00000;
      bitsQ <= 5'h00;
      csQ <= 1'b0;
      skQ <= 1'b0;
      loadIdxQ <= 4'h0;
      tmoQ <= '0;
      rspQ <= '0;
    end else begin
      stateQ <= stateD;
      busyQ <= busyD;
      bootQ <= bootD;
      loadingQ <= loadingD;
      timeoutQ <= timeoutD;
      loadedQ <= loadedD;
      opQ <= opD;
      addrQ <= addrD;
      dataQ <= dataD;
      rxQ <= rxD;
      phaseQ <= phaseD;
      txQ <= txD;
      bitsQ <= bitsD;
      csQ <= csD;
      skQ <= skD;
      loadIdxQ <= loadIdxD;
      tmoQ <= tmoD;
      rspQ <= rspD;
    end
  end

  assign apbRsp = rspQ;
  assign eePins = '{cs: csQ, sk: skQ, dout: txQ[19]};

  cfg_byte_store store (
    .clk(clk),
    .we(storeWe),
    .waddr(3'(loadIdxQ - 4'h1)),
    .wdata(rxQ),
    .raddr(cfgRdAddr),
    .rdata(cfgRdData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_sets_busy: assert property (wrCmd && !busyQ && apbReq.pwdata[31] |=> busyQ)
    else $error("busy not set by start write");
  chk_busy_while_active: assert property (stateQ != eeprom_cmd_pkg::ST_IDLE |-> busyQ)
    else $error("busy low during operation");
  chk_busy_self_clears: assert property (
    stateQ == eeprom_cmd_pkg::ST_NEXT && !loadingQ |=> !busyQ && stateQ == eeprom_cmd_pkg::ST_IDLE)
    else $error("busy did not clear at completion");
  chk_read_data_valid: assert property (stateQ == eeprom_cmd_pkg::ST_NEXT && !loadingQ &&
    opQ == eeprom_cmd_pkg::OP_READ |=> dataQ == $past(rxQ))
    else $error("read byte not placed in data register");
  chk_timeout_flag: assert property (stateQ == eeprom_cmd_pkg::ST_WAIT && !diSync &&
    tmoQ == TMO_LAST |=> timeoutQ ##1 !busyQ)
    else $error("timeout did not flag and release busy");
  chk_reset_busy_op: assert property ($past(rst) |-> busyQ && opQ == 3'h0)
    else $error("busy or command wrong after reset");
  chk_marker_fail: assert property (stateQ == eeprom_cmd_pkg::ST_NEXT && loadingQ &&
    loadIdxQ == 4'h0 && rxQ != 8'ha5 |-> !storeWe ##1 !busyQ && loadedQ == $past(loadedQ))
    else $error("failed reload changed state");
  chk_loaded_set: assert property (stateQ == eeprom_cmd_pkg::ST_NEXT && loadingQ &&
    loadIdxQ == 4'h8 |=> loadedQ && !busyQ)
    else $error("data-loaded not set after load");
  chk_ready_ends_wait: assert property (stateQ == eeprom_cmd_pkg::ST_WAIT && diSync |=>
    stateQ == eeprom_cmd_pkg::ST_NEXT && !csQ)
    else $error("ready from EEPROM not honoured");
  chk_sk_high_time: assert property ($rose(skQ) |-> skQ [*8])
    else $error("serial clock high time too short");
  chk_frame_select: assert property (stateQ == eeprom_cmd_pkg::ST_FRAME |-> csQ)
    else $error("select low during frame");

  cov_read_done: cover property (stateQ == eeprom_cmd_pkg::ST_NEXT && !loadingQ &&
    opQ == eeprom_cmd_pkg::OP_READ);
  cov_timeout: cover property ($rose(timeoutQ));
  cov_load_ok: cover property ($rose(loadedQ));
  cov_write_ready: cover property (stateQ == eeprom_cmd_pkg::ST_WAIT && diSync);

endmodule

// File: design/eeprom_cmd_pkg.sv
/*
  Constants, types and the register map for the serial EEPROM command engine.
  Assumes a 20 MHz clock and a three-wire serial EEPROM with byte organisation.
*/
// Functional notes
// - Writing busy one starts selected command
// - Busy holds during operation, then self-clears
// - Read result appears in data register
// - Write without EEPROM holds busy until timeout
// - Busy high after reset until load ends
// - Three-bit command field, reset zero, eight codes
// - Read fetches addressed byte into data register
// - Write-disable command sent to EEPROM
// - Write-enable command sent to EEPROM
// - Write stores data byte at address
// - Write-all stores data byte everywhere
// - Erase clears the addressed location
// - Erase-all bulk erases whole EEPROM
// - Reload fails unless first byte is marker
// - Failed reload changes no stored contents
// - Successful load sets data-loaded indication
// - No response in window: idle, timeout flag
// - Only write-type commands wait and time out
// - Nine-bit byte address field
// - Data-loaded flag is write-one-to-clear
package eeprom_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_CMD = 8'h30;
  localparam logic [7:0] ADDR_DATA = 8'h34;
  localparam int BUSY_BIT = 31;
  localparam int OP_HI = 30;
  localparam int OP_LO = 28;
  localparam int TIMEOUT_BIT = 10;
  localparam int LOADED_BIT = 9;
  localparam int ADDR_HI = 8;
  localparam logic [2:0] OP_RESET = 3'h0;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Command field encodings
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WDIS = 3'h1;
  localparam logic [2:0] OP_WEN = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_WALL = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  localparam logic [2:0] OP_EALL = 3'h6;
  localparam logic [2:0] OP_RELOAD = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: start bit and opcode, then nine address bits, then eight data bits
  localparam logic [2:0] MW_READ = 3'h6;
  localparam logic [2:0] MW_WRITE = 3'h5;
  localparam logic [2:0] MW_ERASE = 3'h7;
  localparam logic [2:0] MW_SPECIAL = 3'h4;
  localparam logic [1:0] MW_SUB_WEN = 2'h3;
  localparam logic [1:0] MW_SUB_WDIS = 2'h0;
  localparam logic [1:0] MW_SUB_WALL = 2'h1;
  localparam logic [1:0] MW_SUB_EALL = 2'h2;
  localparam logic [4:0] LEN_SHORT = 5'h0c;
  localparam logic [4:0] LEN_LONG = 5'h14;
  localparam logic [7:0] VALID_MARKER = 8'ha5;
  localparam int CFG_BYTES = 8;
  localparam logic [3:0] CFG_LAST = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SK_HALF_NS = 500;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SK_HALF_LAST = 8'(SK_HALF_CYC - 1);
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMO_W = 20;

  typedef enum logic [2:0] {ST_IDLE, ST_FRAME, ST_GAP, ST_WAIT, ST_NEXT} eng_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
  } ee_pins_s;

endpackage

// File: design/cfg_byte_store.sv
/*
  Small store for configuration bytes loaded from the EEPROM.
  Assumes one writer and one reader on the same clock; read data is registered.
*/
module cfg_byte_store (
  input wire logic clk,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [eeprom_cmd_pkg::CFG_BYTES];
  logic [7:0] rdata_q;

  // No reset on the array: contents survive a failed reload untouched
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

  assign rdata = rdata_q;

endmodule

// File: dv/eeprom_model.sv
/*
  Behavioural three-wire serial EEPROM, 512 bytes, byte organised.
  Assumes cs, sk and dout from the engine; din shows the pull level when absent or deselected.
*/
module eeprom_model (
  input wire logic clk,
  input wire logic cs,
  input wire logic sk,
  input wire logic dout,
  input wire logic present,
  input wire logic pullHigh,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  logic [19:0] sr = '0;
  logic [8:0] rdAddr = '0;
  logic wen = 1'b0;
  logic rdOp = 1'b0;
  logic drv = 1'b1;
  int nBits = 0;
  int busyCnt = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[0] = 8'ha5;
    for (int i = 1; i <= 8; i++) begin
      mem[i] = 8'(8'h10 + i);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge cs) begin
    nBits = 0;
    rdOp = 1'b0;
    drv = 1'b1;
  end
  always @(posedge sk) begin
    if (cs) begin
      sr <= {sr[18:0], dout};
      nBits <= nBits + 1;
    end
  end
  // Data bits go out on the fall so they are settled long before the engine samples
  always @(negedge sk) begin
    if (cs && nBits == 12) begin
      rdAddr = sr[8:0];
      rdOp = (sr[10:9] == 2'b10);
    end
    if (cs && rdOp && nBits >= 12 && nBits < 20) begin
      drv <= mem[rdAddr][19 - nBits];
    end
  end
  // Programming only starts when enabled; a disabled part stays ready
  always @(negedge cs) begin
    if (wen && nBits == 20 && sr[18:17] == 2'b01) begin
      mem[sr[16:8]] = sr[7:0];
      busyCnt = 60;
    end
    if (wen && nBits == 20 && sr[18:15] == 4'b0001) begin
      foreach (mem[i]) mem[i] = sr[7:0];
      busyCnt = 60;
    end
    if (wen && nBits == 12 && sr[10:9] == 2'b11) begin
      mem[sr[8:0]] = 8'hff;
      busyCnt = 60;
    end
    if (wen && nBits == 12 && sr[10:7] == 4'b0010) begin
      foreach (mem[i]) mem[i] = 8'hff;
      busyCnt = 60;
    end
    if (nBits == 12 && sr[10:7] == 4'b0011) wen = 1'b1;
    if (nBits == 12 && sr[10:7] == 4'b0000) wen = 1'b0;
  end
  always @(posedge clk) begin
    if (busyCnt > 0) busyCnt <= busyCnt - 1;
  end
  assign din = (!present || !cs) ? pullHigh : ((busyCnt > 0) ? 1'b0 : drv);
endmodule

// File: dv/serial_eeprom_command_engine_tb_top.sv
/*
  Self-checking bench for the EEPROM command engine, driven over APB.
  Assumes eeprom_model on the serial pins and a 20 MHz clock.
*/
module serial_eeprom_command_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short timeout keeps the missing-part case cheap
  localparam int TMO = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  eeprom_cmd_pkg::apb_req_s apbReq = '0;
  eeprom_cmd_pkg::apb_rsp_s apbRsp;
  eeprom_cmd_pkg::ee_pins_s eePins;
  logic din;
  logic [2:0] cfgRdAddr = 3'h0;
  logic [7:0] cfgRdData;
  logic present = 1'b1;
  logic pullHigh = 1'b1;
  int failCount = 0;
  int compares = 0;
  int cycle = 0;
  eeprom_cmd_engine #(.TIMEOUT_CYCLES(TMO)) dut (.clk(clk), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .eePins(eePins), .serialDataInPin(din), .cfgRdAddr(cfgRdAddr),
    .cfgRdData(cfgRdData));
  eeprom_model far (.clk(clk), .cs(eePins.cs), .sk(eePins.sk), .dout(eePins.dout),
    .present(present), .pullHigh(pullHigh), .din(din));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cycle <= cycle + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= wd;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // No cycle count assumed: only the watchdog ends a stalled access
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask
  task automatic runCmd(input logic [2:0] op, input logic [8:0] a, output int cyc);
    logic [31:0] d;
    int t0;
    int n;
    t0 = cycle;
    wrReg(8'h30, {1'b1, op, 19'h0, a});
    n = 0;
    do begin
      rdReg(8'h30, d);
      n++;
    end while (d[31] !== 1'b0 && n < 2000);
    cyc = cycle - t0;
    check("busy clears", {31'h0, d[31]}, 32'h0);
  endtask
  task automatic readByte(input logic [8:0] a, input logic [7:0] exp);
    logic [31:0] d;
    int c;
    runCmd(3'h0, a, c);
    rdReg(8'h34, d);
    check("read byte", d, {24'h0, exp});
  endtask
  task automatic flagIs(input int bitNo, input logic exp);
    logic [31:0] d;
    rdReg(8'h30, d);
    check("status flag", {31'h0, d[bitNo]}, {31'h0, exp});
  endtask
  task automatic cfgIs(input logic [2:0] i, input logic [7:0] exp);
    cfgRdAddr <= i;
    repeat (2) @(posedge clk);
    check("config byte", {24'h0, cfgRdData}, {24'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testPowerUp();
    logic [31:0] d;
    logic e;
    int n;
    rdReg(8'h30, d);
    check("busy at reset", {d[31], 28'h0, d[30:28]}, 32'h8000_0000);
    n = 0;
    while (d[31] !== 1'b0 && n < 3000) begin
      rdReg(8'h30, d);
      n++;
    end
    check("flags after load", d & 32'h8000_0600, 32'h200);
    for (int i = 0; i < 8; i++) begin
      cfgIs(3'(i), 8'(8'h11 + i));
    end
    apb(1'b0, 8'h3c, 32'h0, d, e);
    check("unmapped", {d[30:0], e}, 32'h1);
    wrReg(8'h30, 32'h200);
    flagIs(9, 1'b0);
    $display("power-up test done");
  endtask
  task automatic testReadWrite();
    logic [31:0] d;
    int c;
    wrReg(8'h34, 32'h3c);
    runCmd(3'h3, 9'h1f3, c);
    readByte(9'h1f3, 8'hff);
    runCmd(3'h2, 9'h0, c);
    wrReg(8'h34, 32'h3c);
    runCmd(3'h3, 9'h1f3, c);
    rdReg(8'h30, d);
    check("address field", {20'h0, d[30:28], d[8:0]}, {20'h0, 3'h3, 9'h1f3});
    readByte(9'h1f3, 8'h3c);
    runCmd(3'h5, 9'h1f3, c);
    readByte(9'h1f3, 8'hff);
    runCmd(3'h1, 9'h0, c);
    wrReg(8'h34, 32'h77);
    runCmd(3'h3, 9'h005, c);
    readByte(9'h005, 8'h15);
    $display("read-write test done");
  endtask
  task automatic testBulk();
    int c;
    runCmd(3'h2, 9'h0, c);
    wrReg(8'h34, 32'h5a);
    runCmd(3'h4, 9'h0, c);
    readByte(9'h000, 8'h5a);
    readByte(9'h1ff, 8'h5a);
    runCmd(3'h6, 9'h0, c);
    readByte(9'h008, 8'hff);
    runCmd(3'h7, 9'h0, c);
    flagIs(9, 1'b0);
    cfgIs(3'h0, 8'h11);
    wrReg(8'h34, 32'ha5);
    runCmd(3'h3, 9'h0, c);
    runCmd(3'h7, 9'h0, c);
    flagIs(9, 1'b1);
    cfgIs(3'h0, 8'hff);
    $display("bulk test done");
  endtask
  task automatic testTimeout();
    int c;
    present <= 1'b0;
    pullHigh <= 1'b0;
    runCmd(3'h3, 9'h010, c);
    check("busy held", 32'(c > TMO + 400), 32'h1);
    check("busy bounded", 32'(c < TMO + 1500), 32'h1);
    flagIs(10, 1'b1);
    wrReg(8'h30, 32'h400);
    flagIs(10, 1'b0);
    readByte(9'h010, 8'h00);
    flagIs(10, 1'b0);
    pullHigh <= 1'b1;
    runCmd(3'h5, 9'h010, c);
    flagIs(10, 1'b0);
    present <= 1'b1;
    $display("timeout test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    failCount++;
    $display("CHECK FAILED watchdog expected end seen hang");
    tallyAndFinish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testPowerUp();
    testReadWrite();
    testBulk();
    testTimeout();
    tallyAndFinish();
  end
endmodule
